// >>> hw/timebase_params.svh
// timing-free constants for the capture/compare time base: offsets, fields, reset values
// assumes: included by bare name, before use, by package-aware design files
`ifndef TIMEBASE_PARAMS_SVH
`define TIMEBASE_PARAMS_SVH

// software register offsets of the host end
`define OFS_CONTROL1_LOW   4'h0
`define OFS_CONTROL1_HIGH  4'h1
`define OFS_STATUS_LOW     4'h2
`define OFS_COUNTER_LOW    4'h3
`define OFS_COUNTER_HIGH   4'h4
`define OFS_PERIOD_LOW     4'h5
`define OFS_PERIOD_HIGH    4'h6

// control1_low fields
`define BIT_MODULE_ENABLE  15
`define POS_CLOCK_SOURCE   8
`define BIT_WIDE_COUNTER   5
`define BIT_CAPTURE_SELECT 4
`define POS_OPERATING_MODE 0
// control1_high fields
`define BIT_TRIGGER_ENABLE 7
`define POS_SYNC_SOURCE    0
// status_low fields
`define BIT_TRIGGER_STATUS 7
`define BIT_TRIGGER_CLEAR  5

// codes and reset values
`define CLOCK_SYSTEM       3'h0
`define MODE_TIMER         4'h0
`define SYNC_OFF           5'h00
`define SYNC_SELF          5'h1f
`define SYNC_RESET         5'h0c
`define PERIOD_RESET       16'hffff

`endif

// >>> hw/timebase_pkg.sv
// types shared by both ends of the time base link
// assumes: nothing beyond the params header
package timebase_pkg;

  typedef enum logic [1:0]
  {
    LOAD_COUNTER_LOW  = 2'h0,
    LOAD_COUNTER_HIGH = 2'h1,
    LOAD_PERIOD_LOW   = 2'h2,
    LOAD_PERIOD_HIGH  = 2'h3
  } load_target_t;

endpackage

// >>> hw/timebase_link_if.sv
// link between the software-facing controller and the time base device
// assumes: both ends run on the same system clock
`timescale 1ns/100ps
interface timebase_link_if;
  import timebase_pkg::*;

  logic         moduleEnable;
  logic [2:0]   clockSourceSelect;
  logic         wideCounterSelect;
  logic         captureSelect;
  logic [3:0]   operatingModeField;
  logic [4:0]   syncSourceSelect;
  logic         triggerOperationEnable;
  logic         triggerClear;
  logic         loadStrobe;
  load_target_t loadSelect;
  logic [15:0]  loadData;
  logic [15:0]  counterLow;
  logic [15:0]  counterHigh;
  logic         triggerStatus;

  modport device
  (
    input  moduleEnable, clockSourceSelect, wideCounterSelect, captureSelect,
    input  operatingModeField, syncSourceSelect, triggerOperationEnable, triggerClear,
    input  loadStrobe, loadSelect, loadData,
    output counterLow, counterHigh, triggerStatus
  );

  modport host
  (
    output moduleEnable, clockSourceSelect, wideCounterSelect, captureSelect,
    output operatingModeField, syncSourceSelect, triggerOperationEnable, triggerClear,
    output loadStrobe, loadSelect, loadData,
    input  counterLow, counterHigh, triggerStatus
  );
endinterface

// >>> hw/timebase_device.sv
// time base and general purpose timer of the capture/compare module
// assumes: control from the link is on the system clock; clock source pins are
// asynchronous; event sources come from logic on the system clock
`timescale 1ns/100ps
`include "timebase_params.svh"

// Operation
// [R1] run only in one selected major mode
// [R2] clock chosen from eight by select field
// [R3] every clock source synchronised to system clock
// [R4] timer mode: capture select 0, mode 0000
// [R5] wide select picks dual 16 or 32
// [R6] primary counts low counter against period low; with sync source 00000 it wraps at FFFF instead
// [R7] only primary makes sync, answers sync input
// [R8] secondary counts high against period high
// [R9] secondary match raises compare event flag
// [R10] 32-bit: low overflow increments high half
// [R11] software sets wide select before loading
// [R12] sync source field picks the input
// [R13] sync input clears timer, counting resumes
// [R14] trigger enable picks trigger, else sync
// [R15] software never uses own sync as sync
// [R16] trigger mode holds timer until input
// [R17] timer runs while trigger status set
// [R18] trigger clear stops and zeroes timer
// [R19] trigger mode only with system clock
// [R20] module enable bit gates all operation
// [R21] count per tick, wrap after period match; with sync source 00000 the counter wraps at all ones instead (the dual-mode secondary still wraps at period high)
module timebase_device
  import timebase_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  timebase_link_if.device  link,
  input  wire logic [7:1]  clockSourcePins,
  input  wire logic [31:0] eventSources,
  output logic             syncOut,
  output logic             compareEventFlag
);

  typedef struct packed
  {
    logic [7:1]  clkSyncA;
    logic [7:1]  clkSyncB;
    logic [7:1]  clkSyncC;
    logic [15:0] counterLow;
    logic [15:0] counterHigh;
    logic [15:0] periodLow;
    logic [15:0] periodHigh;
    logic        triggerStatus;
    logic        syncOut;
    logic        compareEvent;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // one tick per system clock, or per rising edge of a synchronised source
  function automatic logic clockTick(input logic [2:0] sel,
                                     input logic [7:1] now,
                                     input logic [7:1] prev);
    logic hit;
    hit = 1'b1;
    if (sel != `CLOCK_SYSTEM)
    begin
      hit = now[sel] & ~prev[sel];
    end
    return hit;
  endfunction

  function automatic logic periodHit16(input logic [15:0] cnt,
                                       input logic [15:0] per,
                                       input logic        freeRun);
    return freeRun ? (cnt == 16'hffff) : (cnt == per);
  endfunction

  logic        timerOn;
  logic        tick;
  logic        syncEvent;
  logic        freeRun;
  logic        triggerMode;
  logic        primaryClear;
  logic [31:0] wideCount;
  logic [31:0] widePeriod;

  always_comb
  begin
    state_nxt          = state_r;
    // first stage read only by the second
    state_nxt.clkSyncA = clockSourcePins;                                  // see [R3]
    state_nxt.clkSyncB = state_r.clkSyncA;                                 // see [R3]
    state_nxt.clkSyncC = state_r.clkSyncB;
    state_nxt.syncOut      = 1'b0;
    state_nxt.compareEvent = 1'b0;

    timerOn = link.moduleEnable                                            // see [R20]
              && !link.captureSelect                                       // see [R1]
              && (link.operatingModeField == `MODE_TIMER);                 // see [R4]
    tick    = clockTick(link.clockSourceSelect,                            // see [R2]
                        state_r.clkSyncB, state_r.clkSyncC);
    freeRun = (link.syncSourceSelect == `SYNC_OFF);

    // selected sync/trigger input; own sync out is usable as a trigger
    syncEvent = 1'b0;                                                      // see [R12]
    if (link.syncSourceSelect == `SYNC_SELF)
    begin
      syncEvent = state_r.syncOut;
    end
    else if (!freeRun)
    begin
      syncEvent = eventSources[link.syncSourceSelect];
    end

    triggerMode  = link.triggerOperationEnable;                            // see [R14]
    primaryClear = 1'b0;
    wideCount    = {state_r.counterHigh, state_r.counterLow};
    widePeriod   = {state_r.periodHigh, state_r.periodLow};

    if (!timerOn)
    begin
      // disabled or in another major mode: time base parked at zero
      state_nxt.counterLow    = 16'h0000;                                  // see [R1]
      state_nxt.counterHigh   = 16'h0000;
      state_nxt.triggerStatus = 1'b0;
    end
    else
    begin
      if (triggerMode)
      begin
        // a trigger in the clearing cycle wins
        state_nxt.triggerStatus = syncEvent                                // see [R16]
                                  | (state_r.triggerStatus & ~link.triggerClear); // see [R18]
        primaryClear = !state_r.triggerStatus || link.triggerClear;        // see [R17]
      end
      else
      begin
        state_nxt.triggerStatus = 1'b0;
        primaryClear = syncEvent;                                          // see [R13]
      end

      if (link.wideCounterSelect)                                          // see [R5]
      begin
        if (primaryClear)
        begin
          wideCount = 32'h0000_0000;
        end
        else if (tick)
        begin
          if (freeRun ? (wideCount == 32'hffff_ffff) : (wideCount == widePeriod))
          begin
            wideCount              = 32'h0000_0000;                        // see [R21]
            state_nxt.syncOut      = 1'b1;
            state_nxt.compareEvent = 1'b1;
          end
          else
          begin
            wideCount = wideCount + 32'h0000_0001;                         // see [R10]
          end
        end
        state_nxt.counterLow  = wideCount[15:0];
        state_nxt.counterHigh = wideCount[31:16];
      end
      else
      begin
        // primary: sync/trigger aware, sole source of sync out
        if (primaryClear)
        begin
          state_nxt.counterLow = 16'h0000;                                 // see [R7]
        end
        else if (tick)
        begin
          if (periodHit16(state_r.counterLow, state_r.periodLow, freeRun))
          begin
            state_nxt.counterLow = 16'h0000;                               // see [R6]
            state_nxt.syncOut    = 1'b1;                                   // see [R7]
          end
          else
          begin
            state_nxt.counterLow = state_r.counterLow + 16'h0001;          // see [R21]
          end
        end
        // secondary: free of sync and trigger, drives only the compare event
        if (tick)
        begin
          if (periodHit16(state_r.counterHigh, state_r.periodHigh, 1'b0))
          begin
            state_nxt.counterHigh  = 16'h0000;                             // see [R8]
            state_nxt.compareEvent = 1'b1;                                 // see [R9]
          end
          else
          begin
            state_nxt.counterHigh = state_r.counterHigh + 16'h0001;        // see [R8]
          end
        end
      end
    end

    // software loads take precedence over counting in the same cycle
    if (link.loadStrobe)
    begin
      unique case (link.loadSelect)
        LOAD_COUNTER_LOW:  state_nxt.counterLow  = link.loadData;
        LOAD_COUNTER_HIGH: state_nxt.counterHigh = link.loadData;
        LOAD_PERIOD_LOW:   state_nxt.periodLow   = link.loadData;
        LOAD_PERIOD_HIGH:  state_nxt.periodHigh  = link.loadData;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r            <= '0;
      state_r.periodLow  <= `PERIOD_RESET;
      state_r.periodHigh <= `PERIOD_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign link.counterLow    = state_r.counterLow;
  assign link.counterHigh   = state_r.counterHigh;
  assign link.triggerStatus = state_r.triggerStatus;
  assign syncOut            = state_r.syncOut;
  assign compareEventFlag   = state_r.compareEvent;

endmodule // timebase_device

// >>> hw/timebase_host.sv
// software-facing controller: holds control bits and drives the time base link
// assumes: software port on the system clock; read data one cycle after strobe
`timescale 1ns/100ps
`include "timebase_params.svh"

module timebase_host
  import timebase_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  timebase_link_if.host    link,
  input  wire logic [3:0]  address,
  input  wire logic [15:0] writeData,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  output logic [15:0]      readData
);

  typedef struct packed
  {
    logic [15:0]  control1Low;
    logic [15:0]  control1High;
    logic         triggerClear;
    logic         loadStrobe;
    load_target_t loadSelect;
    logic [15:0]  loadData;
    logic [15:0]  readData;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [2:0] clockSel;
  logic       trigEnable;
  logic [4:0] syncSel;

  always_comb
  begin
    state_nxt              = state_r;
    state_nxt.triggerClear = 1'b0;
    state_nxt.loadStrobe   = 1'b0;
    state_nxt.readData     = 16'h0000;
    if (writeStrobe)
    begin
      // loads leave in issue order, so a wide-select write first is honoured
      unique case (address)
        `OFS_CONTROL1_LOW:  state_nxt.control1Low  = writeData & 16'h873f;
        `OFS_CONTROL1_HIGH: state_nxt.control1High = writeData & 16'h009f;
        `OFS_STATUS_LOW:    state_nxt.triggerClear = writeData[`BIT_TRIGGER_CLEAR]; // see [R18]
        `OFS_COUNTER_LOW,
        `OFS_COUNTER_HIGH,
        `OFS_PERIOD_LOW,
        `OFS_PERIOD_HIGH:
        begin
          state_nxt.loadStrobe = 1'b1;                                     // see [R11]
          state_nxt.loadSelect = load_target_t'(2'(address - `OFS_COUNTER_LOW));
          state_nxt.loadData   = writeData;
        end
        default: ;
      endcase
    end
    if (readStrobe)
    begin
      unique case (address)
        `OFS_CONTROL1_LOW:  state_nxt.readData = state_r.control1Low;
        `OFS_CONTROL1_HIGH: state_nxt.readData = state_r.control1High;
        `OFS_STATUS_LOW:
          state_nxt.readData = {8'h00, link.triggerStatus, 7'h00};
        `OFS_COUNTER_LOW:   state_nxt.readData = link.counterLow;
        `OFS_COUNTER_HIGH:  state_nxt.readData = link.counterHigh;
        default:            state_nxt.readData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r              <= '0;
      state_r.control1High <= {11'h000, `SYNC_RESET};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign clockSel   = state_r.control1Low[`POS_CLOCK_SOURCE +: 3];
  // trigger only offered on the system clock
  assign trigEnable = state_r.control1High[`BIT_TRIGGER_ENABLE]
                      && (clockSel == `CLOCK_SYSTEM);                      // see [R19]
  // own sync out never used as a sync source
  assign syncSel    = (!trigEnable
                       && state_r.control1High[`POS_SYNC_SOURCE +: 5] == `SYNC_SELF)
                      ? `SYNC_OFF : state_r.control1High[`POS_SYNC_SOURCE +: 5]; // see [R15]

  assign link.moduleEnable           = state_r.control1Low[`BIT_MODULE_ENABLE];
  assign link.clockSourceSelect      = clockSel;
  assign link.wideCounterSelect      = state_r.control1Low[`BIT_WIDE_COUNTER];
  assign link.captureSelect          = state_r.control1Low[`BIT_CAPTURE_SELECT];
  assign link.operatingModeField     = state_r.control1Low[`POS_OPERATING_MODE +: 4];
  assign link.syncSourceSelect       = syncSel;
  assign link.triggerOperationEnable = trigEnable;
  assign link.triggerClear           = state_r.triggerClear;
  assign link.loadStrobe             = state_r.loadStrobe;
  assign link.loadSelect             = state_r.loadSelect;
  assign link.loadData               = state_r.loadData;
  assign readData                    = state_r.readData;

endmodule // timebase_host

// >>> tb/timebase_monitor.sv
// checker for the time base link, the event lines and the two event outputs
// assumes: instantiated beside the link in the bench; one clock domain
`timescale 1ns/100ps
module timebase_monitor
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        moduleEnable,
  input wire logic [2:0]  clockSourceSelect,
  input wire logic        wideCounterSelect,
  input wire logic        captureSelect,
  input wire logic [3:0]  operatingModeField,
  input wire logic [4:0]  syncSourceSelect,
  input wire logic        triggerOperationEnable,
  input wire logic        triggerClear,
  input wire logic        loadStrobe,
  input wire logic [15:0] counterLow,
  input wire logic [15:0] counterHigh,
  input wire logic        triggerStatus,
  input wire logic [31:0] eventSources,
  input wire logic        syncOut,
  input wire logic        compareEventFlag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic run;
  logic ev;
  logic free;
  assign run  = moduleEnable && !captureSelect && operatingModeField == 4'h0;
  assign ev   = eventSources[syncSourceSelect];
  assign free = run && !triggerOperationEnable && syncSourceSelect == 5'h00 && !loadStrobe
                && clockSourceSelect == 3'h0;
  sequence armed_s;
    run && triggerOperationEnable && syncSourceSelect != 5'h1f;
  endsequence
  // source 00000 is the free-running setting and never fires
  sequence fired_s;
    armed_s ##0 (ev && syncSourceSelect != 5'h00);
  endsequence

  mode_gate_a: assert property ((!run) [*2]
    |-> counterLow == 16'h0 && counterHigh == 16'h0 && !triggerStatus)
    else $error("counter moved outside timer mode");
  free_count_a: assert property (free && !wideCounterSelect
    |=> counterLow == $past(counterLow) + 16'h1)
    else $error("free running count step wrong");
  wide_carry_a: assert property (free && wideCounterSelect
    && counterLow == 16'hffff |=> counterHigh == $past(counterHigh) + 16'h1)
    else $error("high half missed the carry");
  sync_clear_a: assert property (run && !triggerOperationEnable
    && syncSourceSelect != 5'h00 && ev && !loadStrobe |=> counterLow == 16'h0)
    else $error("sync event did not clear the timer");
  sync_zero_a: assert property (syncOut && !$past(loadStrobe)
    |-> counterLow == 16'h0)
    else $error("sync output away from wrap");
  compare_zero_a: assert property (compareEventFlag && !$past(loadStrobe)
    |-> counterHigh == 16'h0)
    else $error("compare event away from wrap");
  trig_hold_a: assert property (armed_s ##0 (!triggerStatus || triggerClear)
    ##0 !loadStrobe |=> counterLow == 16'h0)
    else $error("timer ran before trigger");
  trig_set_a: assert property (fired_s |=> triggerStatus)
    else $error("trigger event not taken");
  trig_keep_a: assert property (armed_s ##0 (triggerStatus && !triggerClear)
    |=> triggerStatus)
    else $error("trigger status dropped");
  trig_clear_a: assert property (armed_s ##0 (triggerClear && !ev)
    |=> !triggerStatus)
    else $error("trigger clear ignored");
  host_gate_a: assert property (triggerOperationEnable
    |-> clockSourceSelect == 3'h0)
    else $error("trigger with other clock source");
  self_sync_a: assert property (!triggerOperationEnable
    |-> syncSourceSelect != 5'h1f)
    else $error("own sync used as sync");
endmodule // timebase_monitor

// >>> tb/capture_compare_timebase_bench.sv
// self-checking bench: host and device joined by the link, software port driven here
// assumes: event lines and clock source pins come from this bench only
`timescale 1ns/100ps
module capture_compare_timebase_bench;
  import timebase_pkg::*;
  logic        clock, reset, writeStrobe, readStrobe, syncOut, compareEventFlag, hit;
  logic [3:0]  address;
  logic [15:0] writeData, readData, rv, perL, perH, pL, pH;
  logic [7:1]  clockSourcePins;
  logic [4:0]  sel;
  logic [31:0] eventSources, rnd, curEv, nxtEv, pW;
  logic [15:0] modes [3] = '{16'h8030, 16'h800f, 16'h0000};
  int          mismatches, num_checks;

  timebase_link_if link ();
  timebase_host i_timebase_host (.clock(clock), .reset(reset), .link(link), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData));
  timebase_device i_timebase_device (.clock(clock), .reset(reset), .link(link),
    .clockSourcePins(clockSourcePins), .eventSources(eventSources), .syncOut(syncOut),
    .compareEventFlag(compareEventFlag));
  timebase_monitor i_timebase_monitor (.clock(clock), .reset(reset),
    .moduleEnable(link.moduleEnable), .clockSourceSelect(link.clockSourceSelect),
    .wideCounterSelect(link.wideCounterSelect), .captureSelect(link.captureSelect),
    .operatingModeField(link.operatingModeField), .syncSourceSelect(link.syncSourceSelect),
    .triggerOperationEnable(link.triggerOperationEnable), .triggerClear(link.triggerClear),
    .loadStrobe(link.loadStrobe), .counterLow(link.counterLow), .counterHigh(link.counterHigh),
    .triggerStatus(link.triggerStatus), .eventSources(eventSources), .syncOut(syncOut),
    .compareEventFlag(compareEventFlag));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // next value of a 16-bit timer that wraps after matching its period
  function automatic logic [15:0] nextCount(input logic [15:0] c, input logic [15:0] p);
    return (c == p) ? 16'h0 : c + 16'h1;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    #500000;
    mismatches++;
    results();
  end

  initial
  begin
    reset = 1'b1;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    address = 4'h0;
    writeData = 16'h0;
    clockSourcePins = 7'h0;
    eventSources = 32'h0;
    rnd = 32'h7c31;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd(4'(a), rv);
      check(rv, (a == 1) ? 32'h000c : 32'h0);
    end
    // dual timers with random periods, sync source and sync events
    for (int r = 0; r < 4; r++)
    begin
      rnd = lfsr(rnd);
      perL = {13'h0, rnd[2:0]} + 16'h1;
      perH = {13'h0, rnd[5:3]} + 16'h2;
      sel = 5'(rnd[10:6] % 29 + 1);
      wr(4'h0, 16'h0);
      wr(4'h5, perL);
      wr(4'h6, perH);
      wr(4'h1, {11'h0, sel});
      wr(4'h0, 16'h8000);
      cyc(2);
      pL = link.counterLow;
      pH = link.counterHigh;
      curEv = eventSources;
      repeat (40)
      begin
        rnd = lfsr(rnd);
        nxtEv = rnd & ~(32'h1 << sel);
        if (rnd[9:8] == 2'h0)
          nxtEv = nxtEv | (32'h1 << sel);
        @(posedge clock);
        eventSources <= nxtEv;
        #1;
        hit = curEv[sel];
        check(link.counterLow, hit ? 32'h0 : nextCount(pL, perL));
        check(link.counterHigh, nextCount(pH, perH));
        check(syncOut, !hit && pL == perL);
        check(compareEventFlag, pH == perH);
        pL = link.counterLow;
        pH = link.counterHigh;
        curEv = nxtEv;
      end
      @(posedge clock);
      eventSources <= 32'h0;
    end
    // cascaded counter across the low half overflow
    wr(4'h0, 16'h0);
    wr(4'h1, 16'h0);
    wr(4'h0, 16'h8020);
    wr(4'h4, 16'h0005);
    wr(4'h3, 16'hfff8);
    // the low load lands one edge after the task returns
    cyc(1);
    pW = {link.counterHigh, link.counterLow};
    check(pW, 32'h0005fff8);
    repeat (12)
    begin
      cyc(1);
      check({link.counterHigh, link.counterLow}, pW + 32'h1);
      pW = {link.counterHigh, link.counterLow};
    end
    // trigger: held, fired, running, cleared
    wr(4'h0, 16'h0);
    wr(4'h1, 16'h0083);
    wr(4'h0, 16'h8000);
    cyc(4);
    check(link.counterLow, 32'h0);
    rd(4'h2, rv);
    check(rv, 32'h0);
    @(posedge clock);
    eventSources <= 32'h8;
    @(posedge clock);
    eventSources <= 32'h0;
    cyc(6);
    check(link.counterLow, 32'h6);
    rd(4'h2, rv);
    check(rv, 32'h0080);
    wr(4'h2, 16'h0020);
    cyc(3);
    check(link.triggerStatus, 32'h0);
    cyc(5);
    check(link.counterLow, 32'h0);
    wr(4'h0, 16'h8100);
    cyc(2);
    check(link.triggerOperationEnable, 32'h0);
    wr(4'h1, 16'h001f);
    cyc(2);
    check(link.syncSourceSelect, 32'h0);
    // each slow clock source: three rises of the chosen pin, others toggling
    for (int s = 1; s < 8; s++)
    begin
      wr(4'h0, 16'h0);
      wr(4'h0, 16'h8000 | (16'(s) << 8));
      cyc(2);
      repeat (3)
      begin
        rnd = lfsr(rnd);
        @(posedge clock);
        clockSourcePins <= rnd[6:0] | 7'(1 << (s - 1));
        cyc(3);
        @(posedge clock);
        clockSourcePins <= 7'h0;
        cyc(3);
      end
      cyc(4);
      check(link.counterLow, 32'h3);
    end
    for (int m = 0; m < 3; m++)
    begin
      wr(4'h0, modes[m]);
      cyc(3);
      check({link.counterHigh, link.counterLow}, 32'h0);
    end
    wr(4'h0, 16'h8000);
    cyc(6);
    results();
  end
endmodule // capture_compare_timebase_bench
